// file: logic/external_bus_address_strobes.v
`timescale 1ns/1ps
`include "ext_bus_regs.vh"

module external_bus_address_strobes (
    input  wire        clock_in,
    input  wire        rst_b_in,
    input  wire        req_valid_in,
    output wire        req_ready_out,
    input  wire [23:0] req_addr_in,
    input  wire        req_write_in,
    input  wire        req_word_in,
    input  wire        req_internal_in,
    input  wire [15:0] req_wdata_in,
    input  wire        bus_wide_in,
    input  wire        bus_mux_in,
    input  wire        upper_pin_is_enable_in,
    output wire        rsp_valid_out,
    input  wire        rsp_ready_in,
    output wire [15:0] rsp_rdata_out,
    output wire        rsp_internal_out,
    output wire [15:0] low_address_pins_out,
    output wire [3:0]  upper_address_pins_out,
    input  wire [15:0] shared_addr_data_lines_in,
    output wire [15:0] shared_addr_data_lines_out,
    output wire        shared_addr_data_lines_oe_out,
    output wire        ale_out,
    output wire        address_valid_strobe_n_out,
    output wire        upper_byte_pin_n_out
);

    // ****************************************************************
    // States
    // ****************************************************************
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ADDR = 2'h1;
    localparam [1:0] ST_DATA = 2'h2;
    localparam [1:0] ST_DONE = 2'h3;

    // ****************************************************************
    // Sequencer and pin registers
    // ****************************************************************
    reg [1:0]  state_q;
    reg        boot_q;
    reg        ready_q;
    reg [23:0] addr_q;
    reg        write_q;
    reg        word_q;
    reg        wide_q;
    reg        mux_q;
    reg        internal_q;
    reg        second_q;
    reg [15:0] wdata_q;
    reg [15:0] rdata_q;
    reg [1:0]  cnt_q;
    reg [15:0] lo_addr_q;
    reg [3:0]  up_addr_q;
    reg [15:0] ad_q;
    reg        ad_oe_q;
    reg        ale_q;
    reg        adv_n_q;
    reg        ub_n_q;
    reg        rsp_push_q;
    reg [15:0] rdata_d;

    wire       bhe_n;
    wire       wrh_n;
    wire       low_lane;
    wire       split;
    wire       buf_ready;
    wire       take;
    wire [23:0] cyc_addr;
    wire       last_data;

    // ****************************************************************
    // Cycle address and byte lanes
    // ****************************************************************
    // Word on an 8-bit bus goes out as two byte cycles, low byte first
    assign split    = word_q & ~wide_q;
    // Words on a 16-bit bus are kept aligned so A0 never selects nothing
    assign cyc_addr = (word_q & wide_q) ? {addr_q[23:1], 1'b0} : addr_q;
    assign take     = ready_q & req_valid_in;
    // The data window closes on the last count; the lines are sampled there
    assign last_data = (cnt_q == `DATA_CYCLES - 2'h1);

    byte_lane_decode u_lanes (
        .wide_in                 (wide_q),
        .word_in                 (word_q),
        .a0_in                   (cyc_addr[0]),
        .write_in                (write_q),
        .upper_byte_enable_n_out (bhe_n),
        .upper_byte_write_n_out  (wrh_n),
        .low_lane_out            (low_lane)
    );

    // ****************************************************************
    // Answer buffer
    // ****************************************************************
    // Decouples the sequencer from a receiver that stalls
    resp_skid_buffer #(
        .W (`RSP_W)
    ) u_rsp (
        .clock_in      (clock_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (rsp_push_q),
        .in_ready_out  (buf_ready),
        .in_data_in    ({internal_q, rdata_q}),
        .out_valid_out (rsp_valid_out),
        .out_ready_in  (rsp_ready_in),
        .out_data_out  ({rsp_internal_out, rsp_rdata_out})
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign req_ready_out                 = ready_q;
    assign low_address_pins_out          = lo_addr_q;
    assign upper_address_pins_out        = up_addr_q;
    assign shared_addr_data_lines_out    = ad_q;
    assign shared_addr_data_lines_oe_out = ad_oe_q;
    assign ale_out                       = ale_q;
    assign address_valid_strobe_n_out    = adv_n_q;
    assign upper_byte_pin_n_out          = ub_n_q;

    // ****************************************************************
    // Read data capture
    // ****************************************************************
    // Lanes not addressed keep their value, so a split word builds up
    always @*
    begin
        rdata_d = rdata_q;
        if (wide_q)
        begin
            if (low_lane)
                rdata_d[7:0] = shared_addr_data_lines_in[7:0];
            if (!bhe_n)
                rdata_d[15:8] = shared_addr_data_lines_in[15:8];
        end
        else if (cyc_addr[0])
            rdata_d[15:8] = shared_addr_data_lines_in[7:0];
        else
            rdata_d[7:0] = shared_addr_data_lines_in[7:0];
    end

    // ****************************************************************
    // Bus cycle sequencer
    // ****************************************************************
    always @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_q    <= ST_IDLE;
            boot_q     <= 1'b1;
            ready_q    <= 1'b0;
            addr_q     <= 24'h000000;
            write_q    <= 1'b0;
            word_q     <= 1'b0;
            wide_q     <= 1'b0;
            mux_q      <= 1'b0;
            internal_q <= 1'b0;
            second_q   <= 1'b0;
            wdata_q    <= 16'h0000;
            rdata_q    <= 16'h0000;
            cnt_q      <= 2'h0;
            rsp_push_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    rsp_push_q <= 1'b0;
                    if (boot_q)
                    begin
                        // Reset fetch is a word read from the reset location
                        boot_q     <= 1'b0;
                        addr_q     <= `BOOT_ADDR;
                        write_q    <= 1'b0;
                        word_q     <= 1'b1;
                        wide_q     <= bus_wide_in;
                        mux_q      <= bus_mux_in;
                        internal_q <= 1'b0;
                        second_q   <= 1'b0;
                        rdata_q    <= 16'h0000;
                        state_q    <= ST_ADDR;
                    end
                    else if (take)
                    begin
                        ready_q    <= 1'b0;
                        addr_q     <= req_addr_in;
                        write_q    <= req_write_in;
                        word_q     <= req_word_in;
                        wide_q     <= bus_wide_in;
                        mux_q      <= bus_mux_in;
                        internal_q <= req_internal_in;
                        wdata_q    <= req_wdata_in;
                        second_q   <= 1'b0;
                        rdata_q    <= 16'h0000;
                        // Internal accesses never touch the pins or the strobe
                        state_q    <= req_internal_in ? ST_DONE : ST_ADDR;
                    end
                    else
                        ready_q <= 1'b1;
                end
                ST_ADDR:
                begin
                    cnt_q     <= 2'h0;
                    state_q   <= ST_DATA;
                end
                ST_DATA:
                begin
                    cnt_q <= cnt_q + 2'h1;
                    if (last_data)
                    begin
                        if (!write_q)
                            rdata_q <= rdata_d;
                        if (split && !second_q)
                        begin
                            second_q <= 1'b1;
                            addr_q   <= {addr_q[23:1], 1'b1};
                            state_q  <= ST_ADDR;
                        end
                        else
                            state_q <= ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    // Hold until the buffer has room so no answer is dropped
                    if (rsp_push_q)
                    begin
                        rsp_push_q <= 1'b0;
                        state_q    <= ST_IDLE;
                    end
                    else if (buf_ready)
                        rsp_push_q <= 1'b1;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    // Kept apart from the sequencer; they follow its state one clock later
    always @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            lo_addr_q <= 16'h0000;
            up_addr_q <= 4'h0;
            ad_q      <= 16'h0000;
            ad_oe_q   <= 1'b0;
            ale_q     <= 1'b0;
            adv_n_q   <= 1'b1;
            ub_n_q    <= 1'b1;
        end
        else
        begin
            case (state_q)
                ST_ADDR:
                begin
                    // Only the low 20 bits of the internal address leave the chip
                    lo_addr_q <= cyc_addr[15:0];
                    up_addr_q <= cyc_addr[19:16];
                    ale_q     <= 1'b1;
                    adv_n_q   <= 1'b0;
                    ad_q      <= mux_q ? cyc_addr[15:0] : 16'h0000;
                    ad_oe_q   <= mux_q;
                    ub_n_q    <= upper_pin_is_enable_in ? bhe_n : 1'b1;
                end
                ST_DATA:
                begin
                    ale_q   <= 1'b0;
                    adv_n_q <= 1'b1;
                    ad_oe_q <= write_q;
                    // An 8-bit bus carries either byte on the low lane
                    if (!wide_q)
                        ad_q <= {8'h00, cyc_addr[0] ? wdata_q[15:8] : wdata_q[7:0]};
                    else
                        ad_q <= wdata_q;
                    if (upper_pin_is_enable_in)
                        ub_n_q <= bhe_n;
                    else
                        ub_n_q <= wrh_n;
                end
                ST_DONE:
                begin
                    // Release the shared lines; address pins keep the last address
                    ad_oe_q <= 1'b0;
                    ub_n_q  <= 1'b1;
                end
                default:
                begin
                    ale_q   <= 1'b0;
                    adv_n_q <= 1'b1;
                end
            endcase
        end
    end
endmodule // external_bus_address_strobes

// file: logic/ext_bus_regs.vh
`ifndef EXT_BUS_REGS_VH
`define EXT_BUS_REGS_VH

// ********************************************************************
// Address and data widths
// ********************************************************************
`define INT_ADDR_W      24
`define EXT_ADDR_W      20
`define DATA_W          16

// ********************************************************************
// Reset fetch location, bus timing and answer width
// ********************************************************************
`define BOOT_ADDR       24'hFF2080
`define DATA_CYCLES     2'h2
`define RSP_W           17

`endif

// file: logic/resp_skid_buffer.v
`timescale 1ns/1ps

// ********************************************************************
// Two-entry buffer; slot zero is always the head so outputs are flops
// ********************************************************************
module resp_skid_buffer #(
    parameter W = 17
) (
    input  wire         clock_in,
    input  wire         rst_b_in,
    input  wire         in_valid_in,
    output wire         in_ready_out,
    input  wire [W-1:0] in_data_in,
    output wire         out_valid_out,
    input  wire         out_ready_in,
    output wire [W-1:0] out_data_out
);
    reg         v0_q;
    reg         v1_q;
    reg [W-1:0] d0_q;
    reg [W-1:0] d1_q;
    wire        push;
    wire        pop;

    assign push          = in_valid_in & ~v1_q;
    assign pop           = v0_q & out_ready_in;
    assign in_ready_out  = ~v1_q;
    assign out_valid_out = v0_q;
    assign out_data_out  = d0_q;

    always @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            v0_q <= 1'b0;
            v1_q <= 1'b0;
            d0_q <= {W{1'b0}};
            d1_q <= {W{1'b0}};
        end
        else if (pop)
        begin
            if (v1_q)
            begin
                d0_q <= d1_q;
                if (push)
                    d1_q <= in_data_in;
                else
                    v1_q <= 1'b0;
            end
            else if (push)
                d0_q <= in_data_in;
            else
                v0_q <= 1'b0;
        end
        else if (push)
        begin
            if (!v0_q)
            begin
                d0_q <= in_data_in;
                v0_q <= 1'b1;
            end
            else
            begin
                d1_q <= in_data_in;
                v1_q <= 1'b1;
            end
        end
    end
endmodule // resp_skid_buffer

// file: logic/byte_lane_decode.v
`timescale 1ns/1ps

// ********************************************************************
// Upper-byte enable and upper-byte write strobe from size and A0
// ********************************************************************
module byte_lane_decode (
    input  wire wide_in,
    input  wire word_in,
    input  wire a0_in,
    input  wire write_in,
    output wire upper_byte_enable_n_out,
    output wire upper_byte_write_n_out,
    output wire low_lane_out
);
    wire upper_used;

    // Word or odd byte on a 16-bit bus uses the upper half
    assign upper_used              = wide_in & (word_in | a0_in);
    assign upper_byte_enable_n_out = ~upper_used;
    assign upper_byte_write_n_out  = ~(upper_used & write_in);
    assign low_lane_out            = ~wide_in | word_in | ~a0_in;
endmodule // byte_lane_decode

// file: test/ext_bus_chk.sv
`timescale 1ns/1ps
module ext_bus_chk (
    input wire        clock_in,
    input wire        rst_b_in,
    input wire        req_valid_in,
    input wire        req_ready_out,
    input wire        req_internal_in,
    input wire        bus_wide_in,
    input wire        bus_mux_in,
    input wire        upper_pin_is_enable_in,
    input wire        rsp_valid_out,
    input wire        rsp_ready_in,
    input wire [15:0] rsp_rdata_out,
    input wire [15:0] low_address_pins_out,
    input wire [3:0]  upper_address_pins_out,
    input wire [15:0] shared_addr_data_lines_out,
    input wire        shared_addr_data_lines_oe_out,
    input wire        ale_out,
    input wire        address_valid_strobe_n_out,
    input wire        upper_byte_pin_n_out
);
    reg  boot_q;
    wire take = req_valid_in && req_ready_out;
    wire lo0  = low_address_pins_out[0];
    // Cleared by the first strobe so only the fetch after reset is judged
    always @(posedge clock_in or negedge rst_b_in)
        if (!rst_b_in)
            boot_q <= 1'h1;
        else if (ale_out)
            boot_q <= 1'h0;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    strobe_pair_a: assert property (ale_out == !address_valid_strobe_n_out)
        else $error("strobes disagree");
    ale_pulse_a: assert property (ale_out |=> !ale_out)
        else $error("latch strobe too long");
    addr_hold_a: assert property (!ale_out |-> $stable({upper_address_pins_out,
        low_address_pins_out})) else $error("address moved mid cycle");
    boot_addr_a: assert property (ale_out && boot_q |-> low_address_pins_out == 16'h2080
        && upper_address_pins_out == 4'hF) else $error("wrong first address");
    ext_start_a: assert property (take && !req_internal_in |-> ##[1:3] ale_out)
        else $error("no strobe for bus cycle");
    int_quiet_a: assert property (take && req_internal_in |=> !ale_out [*4])
        else $error("strobe on internal access");
    mux_addr_a: assert property (ale_out && bus_mux_in |-> shared_addr_data_lines_oe_out
        && shared_addr_data_lines_out == low_address_pins_out) else $error("no mux address");
    high_byte_a: assert property (ale_out && bus_wide_in && upper_pin_is_enable_in
        && lo0 |-> !upper_byte_pin_n_out) else $error("no byte selected");
    upper_idle_a: assert property (ale_out && !(bus_wide_in && upper_pin_is_enable_in)
        |-> upper_byte_pin_n_out) else $error("upper pin low in address phase");
    rsp_hold_a: assert property (rsp_valid_out && !rsp_ready_in |=> rsp_valid_out
        && $stable(rsp_rdata_out)) else $error("answer lost in stall");
    cover property (take && req_internal_in);
    cover property (!upper_pin_is_enable_in && !upper_byte_pin_n_out);
    cover property (rsp_valid_out && !rsp_ready_in && !req_ready_out);
endmodule // ext_bus_chk

// file: test/ext_mem_model.sv
`timescale 1ns/1ps
module ext_mem_model (
    input  wire        clock_in,
    input  wire        ale_in,
    input  wire        oe_in,
    input  wire [15:0] addr_pins_in,
    input  wire [15:0] ad_in,
    output wire [15:0] drive_out
);
    reg [15:0] lat_q = 16'h0;
    reg [15:0] noise_q = 16'h0;
    reg [2:0]  cnt_q = 3'h0;
    always @(posedge clock_in)
    begin
        if (ale_in)
            lat_q <= oe_in ? ad_in : addr_pins_in;
        cnt_q <= ale_in ? 3'h1 : ((cnt_q != 3'h0 && cnt_q < 3'h4) ? cnt_q + 3'h1 : 3'h0);
        noise_q <= ~noise_q;
    end
    // Outside the data window the lines toggle so stale data never matches
    assign drive_out = (cnt_q != 3'h0) ? (lat_q ^ 16'h5A3C) : noise_q;
endmodule // ext_mem_model

// file: test/external_bus_address_strobes_tb_top.sv
`timescale 1ns/1ps
module external_bus_address_strobes_tb_top;
    reg         clock_in = 1'h0;
    reg         rst_b_in = 1'h0;
    reg         vld = 1'h0, wr = 1'h0, wd = 1'h0, intl = 1'h0;
    reg         wide = 1'h1, mux = 1'h1, ube_en = 1'h1, rdy = 1'h1;
    reg  [23:0] addr = 24'h0;
    reg  [15:0] wdata = 16'h0;
    reg  [19:0] seen_addr = 20'h0;
    reg  [15:0] seen_wd = 16'h0;
    reg         seen_ube = 1'h0, ube_low = 1'h0;
    wire        ready, rsp_valid, rsp_int, ale, adv_n, ube_n, oe;
    wire [15:0] rdata, lo_pins, ad_out, mem_ad;
    wire [3:0]  up_pins;
    wire [15:0] ad_wire = oe ? ad_out : mem_ad;
    integer     n_errors = 0, checked = 0, n_ale = 0, n0;
    external_bus_address_strobes u_external_bus_address_strobes (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .req_valid_in(vld), .req_ready_out(ready),
        .req_addr_in(addr), .req_write_in(wr), .req_word_in(wd), .req_internal_in(intl),
        .req_wdata_in(wdata), .bus_wide_in(wide), .bus_mux_in(mux),
        .upper_pin_is_enable_in(ube_en), .rsp_valid_out(rsp_valid), .rsp_ready_in(rdy),
        .rsp_rdata_out(rdata), .rsp_internal_out(rsp_int), .low_address_pins_out(lo_pins),
        .upper_address_pins_out(up_pins), .shared_addr_data_lines_in(ad_wire),
        .shared_addr_data_lines_out(ad_out), .shared_addr_data_lines_oe_out(oe),
        .ale_out(ale), .address_valid_strobe_n_out(adv_n), .upper_byte_pin_n_out(ube_n));
    ext_mem_model u_ext_mem_model (.clock_in(clock_in), .ale_in(ale), .oe_in(oe),
        .addr_pins_in(lo_pins), .ad_in(ad_out), .drive_out(mem_ad));
    initial
        forever #12.5 clock_in = ~clock_in;
    always @(posedge clock_in)
    begin
        if (ale)
        begin
            n_ale <= n_ale + 1;
            seen_addr <= {up_pins, lo_pins};
            seen_ube <= ube_n;
            ube_low <= 1'h0;
        end
        else if (!ube_n)
            ube_low <= 1'h1;
        if (oe && !ale)
            seen_wd <= ad_out;
    end
    function [15:0] fm(input [15:0] a);
        fm = a ^ 16'h5A3C;
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
    begin
        checked = checked + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task results;
    begin
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    task issue(input [23:0] a, input w, input word, input in, input [15:0] d);
        integer i;
    begin
        @(negedge clock_in);
        {addr, wr, wd, intl, wdata, vld} = {a, w, word, in, d, 1'h1};
        for (i = 0; i < 200 && ready !== 1'h1; i = i + 1)
            @(negedge clock_in);
        @(negedge clock_in);
        vld = 1'h0;
    end
    endtask
    task answer(input [15:0] exp, input in);
        integer i;
    begin
        for (i = 0; i < 200 && rsp_valid !== 1'h1; i = i + 1)
            @(negedge clock_in);
        check(rdata, exp);
        check(rsp_int, in);
        // Let the pop edge pass so the next look never races the buffer
        @(negedge clock_in);
    end
    endtask
    task xfer(input [23:0] a, input w, input word, input in, input [15:0] d, input [15:0] e);
    begin
        issue(a, w, word, in, d);
        answer(e, in);
    end
    endtask
    task lane(input [23:0] a, input word, input [15:0] e, input ub, input a0);
    begin
        xfer(a, 1'h0, word, 1'h0, 16'h0, e);
        check(seen_ube, ub);
        check(seen_addr[0], a0);
    end
    endtask
    task t_boot;
    begin
        answer(fm(16'h2080), 1'h0);
        check(seen_addr, 20'hF2080);
        check(n_ale, 1);
        $display("boot fetch done");
    end
    endtask
    task t_mux;
    begin
        xfer(24'h3ABCD4, 1'h0, 1'h1, 1'h0, 16'h0, fm(16'hBCD4));
        check(seen_addr, 20'hABCD4);
        check(seen_ube, 1'h0);
        $display("multiplexed word done");
    end
    endtask
    task t_lanes;
    begin
        mux = 1'h0;
        lane(24'h012340, 1'h0, {8'h00, fm(16'h2340) & 16'h00FF}, 1'h1, 1'h0);
        lane(24'h012341, 1'h0, fm(16'h2341) & 16'hFF00, 1'h0, 1'h1);
        lane(24'h012343, 1'h1, fm(16'h2342), 1'h0, 1'h0);
        $display("byte lanes done");
    end
    endtask
    task t_narrow;
    begin
        wide = 1'h0;
        n0 = n_ale;
        xfer(24'h045678, 1'h0, 1'h1, 1'h0, 16'h0, ((fm(16'h5679) & 16'h00FF) << 8) |
            (fm(16'h5678) & 16'h00FF));
        check(n_ale - n0, 2);
        check(seen_addr, 20'h45679);
        check(seen_ube, 1'h1);
        wide = 1'h1;
        $display("narrow bus word done");
    end
    endtask
    task t_wstrobe;
    begin
        {mux, ube_en} = 2'h2;
        xfer(24'h006AA2, 1'h1, 1'h1, 1'h0, 16'hC35A, 16'h0);
        check(seen_ube, 1'h1);
        check(ube_low, 1'h1);
        check(seen_wd, 16'hC35A);
        ube_en = 1'h1;
        $display("upper write strobe done");
    end
    endtask
    task t_internal;
    begin
        n0 = n_ale;
        xfer(24'h000100, 1'h0, 1'h1, 1'h1, 16'h0, 16'h0);
        check(n_ale - n0, 0);
        $display("internal access done");
    end
    endtask
    task t_stall;
    begin
        rdy = 1'h0;
        issue(24'h00A000, 1'h0, 1'h1, 1'h0, 16'h0);
        issue(24'h00A002, 1'h0, 1'h1, 1'h0, 16'h0);
        issue(24'h00A004, 1'h0, 1'h1, 1'h0, 16'h0);
        repeat (20) @(negedge clock_in);
        check(ready, 1'h0);
        rdy = 1'h1;
        answer(fm(16'hA000), 1'h0);
        answer(fm(16'hA002), 1'h0);
        answer(fm(16'hA004), 1'h0);
        $display("stalled receiver done");
    end
    endtask
    initial
    begin
        #500000;
        n_errors = n_errors + 1;
        results;
    end
    initial
    begin
        repeat (8) @(posedge clock_in);
        @(negedge clock_in);
        rst_b_in = 1'h1;
        t_boot;
        t_mux;
        t_lanes;
        t_narrow;
        t_wstrobe;
        t_internal;
        t_stall;
        results;
    end
endmodule // external_bus_address_strobes_tb_top
bind external_bus_address_strobes ext_bus_chk u_ext_bus_chk (.*);
